// >>> hdl/bcc_defines.vh
`ifndef BCC_DEFINES_VH
`define BCC_DEFINES_VH

// Register map (byte addresses on the APB)
`define BCC_ADDR_W              12
`define BCC_BUS_CONTROL_ONE     12'h000

// Field positions of bus_control_one
`define BCC_RSVD_HI             15
`define BCC_RSVD_LO             14
`define BCC_STANDBY_MEM_DRIVE   13
`define BCC_STROBE_DRIVE_CTRL   12
`define BCC_ENDIAN              11
`define BCC_AREA0_BURST_HI      10
`define BCC_AREA0_BURST_LO      9
`define BCC_AREA5_BURST_HI      8
`define BCC_AREA5_BURST_LO      7
`define BCC_AREA6_BURST_HI      6
`define BCC_AREA6_BURST_LO      5
`define BCC_MEMTYPE_HI          4
`define BCC_MEMTYPE_LO          2
`define BCC_AREA5_CARD_SPACE    1
`define BCC_AREA6_CARD_SPACE    0

// Reset value and software-writable bits
`define BCC_RESET_VALUE         16'h0000
`define BCC_WRITE_MASK          16'h37FF

// Memory type codes for areas 2 and 3
`define BCC_MT_NORMAL           3'h0
`define BCC_MT_A3_PSRAM         3'h1
`define BCC_MT_A3_SDRAM         3'h2
`define BCC_MT_BOTH_SDRAM       3'h3
`define BCC_MT_A3_DRAM          3'h4
`define BCC_MT_BOTH_DRAM        3'h5

// Burst counts
`define BCC_BURST_NONE          5'h00
`define BCC_BURST_4             5'h04
`define BCC_BURST_8             5'h08
`define BCC_BURST_16            5'h10

// Cycles after reset release before the strap is taken (sync depth plus one)
`define BCC_STRAP_WAIT          2'h3

`endif

// >>> hdl/bcc_sync2.v
`timescale 1ns/1ps
module bcc_sync2
(
   input  wire clk_i,
   input  wire rst_n_i,
   input  wire d_i,
   output reg  q_o
);

   reg meta_q;

   // First stage is seen only by the second stage
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_q <= 1'b0;
         q_o    <= 1'b0;
      end
      else
      begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end

endmodule // bcc_sync2

// >>> hdl/bcc_bus_control.v
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "bcc_defines.vh"
module bcc_bus_control
(
   input  wire        mclk_i,
   input  wire        nrst_i,
   // APB slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   // State of the bus controller, same clock
   input  wire        standby_i,
   input  wire        bus_released_i,
   input  wire        row_strobe_two_i,
   input  wire        card_enable_a_i,
   input  wire        card_enable_b_i,
   // Endian strap pin, shared with row strobe two
   input  wire        endian_strap_pin_i,
   output reg         endian_strap_pin_o,
   output reg         endian_strap_pin_oe_o,
   // Mode pins three and four, shared with the card enables
   output reg         mode_pin_three_o,
   output reg         mode_pin_three_oe_o,
   output reg         mode_pin_four_o,
   output reg         mode_pin_four_oe_o,
   // Pin group enables
   output reg         mem_pins_oe_o,
   output reg         strobe_pins_oe_o,
   // Decoded configuration
   output reg         little_endian_o,
   output reg  [4:0]  area0_burst_len_o,
   output reg  [4:0]  area5_burst_len_o,
   output reg  [4:0]  area6_burst_len_o,
   output reg         area2_sdram_o,
   output reg         area2_dram_o,
   output reg         area3_psram_o,
   output reg         area3_sdram_o,
   output reg         area3_dram_o,
   output reg         area5_card_o,
   output reg         area6_card_o
);

   wire        rst_n;
   wire        strap_sync;

   reg  [15:0] bus_control_one_q;
   reg  [15:0] bus_control_one_d;
   reg  [1:0]  strap_cnt_q;
   reg         strap_taken_q;
   reg         endian_q;

   wire        sel_reg;
   wire        access;
   wire        commit;
   wire [15:0] read_value;

   // Reset release through two flops; this reset is power-on only
   bcc_sync2 u_rst_sync
   (
      .clk_i   (mclk_i),
      .rst_n_i (nrst_i),
      .d_i     (1'b1),
      .q_o     (rst_n)
   );

   bcc_sync2 u_strap_sync
   (
      .clk_i   (mclk_i),
      .rst_n_i (rst_n),
      .d_i     (endian_strap_pin_i),
      .q_o     (strap_sync)
   );

   function [4:0] burst_len;
      input [1:0] code;
      begin
         case (code)
            2'b01:   burst_len = `BCC_BURST_4;
            2'b10:   burst_len = `BCC_BURST_8;
            2'b11:   burst_len = `BCC_BURST_16;
            default: burst_len = `BCC_BURST_NONE;
         endcase
      end
   endfunction

   // Strap is taken once the synchroniser holds a real pin sample; it is
   // ignored afterwards, so the pin may become an output later.
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strap_cnt_q   <= 2'h0;
         strap_taken_q <= 1'b0;
         endian_q      <= 1'b0;
      end
      else if (!strap_taken_q)
      begin
         if (strap_cnt_q == `BCC_STRAP_WAIT)
         begin
            strap_taken_q <= 1'b1;
            endian_q      <= strap_sync;
         end
         else
         begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
         end
      end
   end

   // Single register decode; other addresses answer with an error
   assign sel_reg = (paddr_i == `BCC_BUS_CONTROL_ONE);
   assign access  = psel_i & penable_i;
   assign commit  = access & pready_o;

   // Endian bit comes from the strap flop, reserved bits are constant zero
   assign read_value = {2'b00, bus_control_one_q[13:12], endian_q, bus_control_one_q[10:0]};

   always @*
   begin
      bus_control_one_d = bus_control_one_q;
      if (commit && pwrite_i && sel_reg)
      begin
         bus_control_one_d = pwdata_i[15:0] & `BCC_WRITE_MASK;
      end
   end

   // Only the power-on reset clears it; standby_i does not affect it and there is no manual reset input
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_control_one_q <= `BCC_RESET_VALUE;
      end
      else
      begin
         bus_control_one_q <= bus_control_one_d;
      end
   end

   // One wait state: answer at the second access cycle, then drop
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end
      else if (access && !pready_o)
      begin
         pready_o  <= 1'b1;
         pslverr_o <= ~sel_reg;
         if (!pwrite_i && sel_reg)
         begin
            prdata_o <= {16'h0000, read_value};
         end
         else
         begin
            prdata_o <= 32'h0000_0000;
         end
      end
      else
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

   // Decoded configuration and pin control, all registered
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         little_endian_o       <= 1'b0;
         area0_burst_len_o     <= `BCC_BURST_NONE;
         area5_burst_len_o     <= `BCC_BURST_NONE;
         area6_burst_len_o     <= `BCC_BURST_NONE;
         area2_sdram_o         <= 1'b0;
         area2_dram_o          <= 1'b0;
         area3_psram_o         <= 1'b0;
         area3_sdram_o         <= 1'b0;
         area3_dram_o          <= 1'b0;
         area5_card_o          <= 1'b0;
         area6_card_o          <= 1'b0;
         mem_pins_oe_o         <= 1'b0;
         strobe_pins_oe_o      <= 1'b0;
         endian_strap_pin_o    <= 1'b0;
         endian_strap_pin_oe_o <= 1'b0;
         mode_pin_three_o      <= 1'b0;
         mode_pin_three_oe_o   <= 1'b0;
         mode_pin_four_o       <= 1'b0;
         mode_pin_four_oe_o    <= 1'b0;
      end
      else
      begin
         little_endian_o   <= endian_q;
         area0_burst_len_o <= burst_len(bus_control_one_q[`BCC_AREA0_BURST_HI:`BCC_AREA0_BURST_LO]);
         area5_burst_len_o <= burst_len(bus_control_one_q[`BCC_AREA5_BURST_HI:`BCC_AREA5_BURST_LO]);
         area6_burst_len_o <= burst_len(bus_control_one_q[`BCC_AREA6_BURST_HI:`BCC_AREA6_BURST_LO]);

         // Reserved codes fall to normal memory so a bad write cannot enable DRAM
         area2_sdram_o <= 1'b0;
         area2_dram_o  <= 1'b0;
         area3_psram_o <= 1'b0;
         area3_sdram_o <= 1'b0;
         area3_dram_o  <= 1'b0;
         case (bus_control_one_q[`BCC_MEMTYPE_HI:`BCC_MEMTYPE_LO])
            `BCC_MT_A3_PSRAM:
            begin
               area3_psram_o <= 1'b1;
            end
            `BCC_MT_A3_SDRAM:
            begin
               area3_sdram_o <= 1'b1;
            end
            `BCC_MT_BOTH_SDRAM:
            begin
               area2_sdram_o <= 1'b1;
               area3_sdram_o <= 1'b1;
            end
            `BCC_MT_A3_DRAM:
            begin
               area3_dram_o <= 1'b1;
            end
            `BCC_MT_BOTH_DRAM:
            begin
               area2_dram_o <= 1'b1;
               area3_dram_o <= 1'b1;
            end
            default:
            begin
               area3_dram_o <= 1'b0;
            end
         endcase

         area5_card_o <= bus_control_one_q[`BCC_AREA5_CARD_SPACE];
         area6_card_o <= bus_control_one_q[`BCC_AREA6_CARD_SPACE];

         mem_pins_oe_o    <= ~standby_i | bus_control_one_q[`BCC_STANDBY_MEM_DRIVE];
         strobe_pins_oe_o <= ~(standby_i | bus_released_i) | bus_control_one_q[`BCC_STROBE_DRIVE_CTRL];

         // Strap pin stays an input until both areas are DRAM
         if (bus_control_one_q[`BCC_MEMTYPE_HI:`BCC_MEMTYPE_LO] == `BCC_MT_BOTH_DRAM)
         begin
            endian_strap_pin_o    <= row_strobe_two_i;
            endian_strap_pin_oe_o <= ~(standby_i | bus_released_i)
                                     | bus_control_one_q[`BCC_STROBE_DRIVE_CTRL];
         end
         else
         begin
            endian_strap_pin_o    <= 1'b0;
            endian_strap_pin_oe_o <= 1'b0;
         end

         // Mode pins are strap inputs unless card space is chosen
         mode_pin_three_o    <= card_enable_a_i & bus_control_one_q[`BCC_AREA5_CARD_SPACE];
         mode_pin_three_oe_o <= bus_control_one_q[`BCC_AREA5_CARD_SPACE]
                                & (~standby_i | bus_control_one_q[`BCC_STANDBY_MEM_DRIVE]);
         mode_pin_four_o     <= card_enable_b_i & bus_control_one_q[`BCC_AREA6_CARD_SPACE];
         mode_pin_four_oe_o  <= bus_control_one_q[`BCC_AREA6_CARD_SPACE]
                                & (~standby_i | bus_control_one_q[`BCC_STANDBY_MEM_DRIVE]);
      end
   end

endmodule // bcc_bus_control

// >>> tb/bcc_pin_model.sv
`timescale 1ns/1ps
module bcc_pin_model
(
   input  wire strap_i,
   input  wire drv_i,
   input  wire drv_oe_i,
   output wire pin_o
);
   // The strap resistor sets the level whenever the controller lets go of the pin
   assign pin_o = drv_oe_i ? drv_i : strap_i;
endmodule // bcc_pin_model

// >>> tb/bcc_checker.sv
`timescale 1ns/1ps
`include "bcc_defines.vh"
module bcc_checker
(
   input wire        mclk_i,
   input wire        nrst_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire        standby_i,
   input wire        bus_released_i,
   input wire        row_strobe_two_i,
   input wire        endian_strap_pin_o,
   input wire        endian_strap_pin_oe_o,
   input wire        mem_pins_oe_o,
   input wire        strobe_pins_oe_o,
   input wire [4:0]  area0_burst_len_o,
   input wire [4:0]  area5_burst_len_o,
   input wire        area2_dram_o,
   input wire        area3_dram_o,
   input wire        area5_card_o,
   input wire        area6_card_o
);
   reg  [15:0] sh_q;
   reg  [2:0]  up_q;
   wire        ok = (up_q == 3'h7);
   function [4:0] bl(input [1:0] c);
      bl = (c == 2'h0) ? 5'h00 : 5'h02 << c;
   endfunction
   // Shadow copy fed by completed writes; ok skips the internal reset sync and strap wait
   always @(posedge mclk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         sh_q <= 16'h0000;
         up_q <= 3'h0;
      end
      else
      begin
         if (up_q != 3'h7)
            up_q <= up_q + 3'h1;
         if (pready_o && pwrite_i && !pslverr_o)
            sh_q <= pwdata_i[15:0] & `BCC_WRITE_MASK;
      end
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_access;
      psel_i && penable_i;
   endsequence
   AST_PREADY: assert property (s_setup ##1 s_access |-> !pready_o ##1 pready_o ##1 !pready_o)
      else $error("pready not in second access cycle");
   AST_RSVD: assert property (pready_o && !pwrite_i |-> prdata_o[31:14] == 18'h0_0000)
      else $error("reserved read bits not zero");
   AST_MEM_OE: assert property (ok |-> mem_pins_oe_o == !$past(standby_i && !sh_q[13]))
      else $error("memory pin enable wrong");
   AST_STROBE_OE: assert property (ok |->
      strobe_pins_oe_o == !$past((standby_i || bus_released_i) && !sh_q[12]))
      else $error("strobe pin enable wrong");
   AST_BURST: assert property (ok |-> area0_burst_len_o == bl($past(sh_q[10:9]))
      && area5_burst_len_o == bl($past(sh_q[8:7])))
      else $error("burst length wrong");
   AST_MEMTYPE: assert property (ok |-> area2_dram_o == ($past(sh_q[4:2]) == `BCC_MT_BOTH_DRAM)
      && area3_dram_o == ($past(sh_q[4:3]) == 2'h2))
      else $error("memory type decode wrong");
   AST_CARD: assert property (ok |-> {area5_card_o, area6_card_o} == $past(sh_q[1:0]))
      else $error("card space flags wrong");
   AST_ROW_STROBE_TWO: assert property (ok && endian_strap_pin_oe_o |->
      $past(sh_q[4:2]) == `BCC_MT_BOTH_DRAM && endian_strap_pin_o == $past(row_strobe_two_i))
      else $error("row strobe two pin wrong");
endmodule // bcc_checker

bind bcc_bus_control bcc_checker i_chk (.*);

// >>> tb/bus_control_config_register_tb_top.sv
`timescale 1ns/1ps
module bus_control_config_register_tb_top;
   reg         mclk_i, nrst_i, psel_i, penable_i, pwrite_i, strap;
   reg         standby_i, bus_released_i, row_strobe_two_i, card_enable_a_i, card_enable_b_i;
   reg  [11:0] paddr_i;
   reg  [31:0] pwdata_i;
   wire [31:0] prdata_o;
   wire        pready_o, pslverr_o, endian_strap_pin_i, endian_strap_pin_o, endian_strap_pin_oe_o;
   wire        mode_pin_three_o, mode_pin_three_oe_o, mode_pin_four_o, mode_pin_four_oe_o;
   wire        mem_pins_oe_o, strobe_pins_oe_o, little_endian_o, area5_card_o, area6_card_o;
   wire        area2_sdram_o, area2_dram_o, area3_psram_o, area3_sdram_o, area3_dram_o;
   wire [4:0]  area0_burst_len_o, area5_burst_len_o, area6_burst_len_o;
   integer     n_mismatch, cmp_count, seed, i;
   reg  [31:0] r;
   reg  [15:0] v;
   reg  [33:0] note;
   reg  [33:0] q[$];
   localparam [29:0] MT = {5'h18, 5'h08, 5'h06, 5'h02, 5'h01, 5'h00};

   bcc_bus_control i_dut (.*);
   bcc_pin_model i_pin (.strap_i(strap), .drv_i(endian_strap_pin_o), .drv_oe_i(endian_strap_pin_oe_o),
      .pin_o(endian_strap_pin_i));

   always #12.5 mclk_i = ~mclk_i;

   function [4:0] bl(input [1:0] c);
      bl = (c == 2'h0) ? 5'h00 : 5'h02 << c;
   endfunction

   task automatic chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // The note holds direction, expected error and expected read data
   task apb(input w, input [11:0] a, input [15:0] d, input [15:0] e);
      begin
         q.push_back({w, a != 12'h000, 16'h0000, e});
         @(posedge mclk_i);
         psel_i <= 1'b1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= {d, d};
         @(posedge mclk_i);
         penable_i <= 1'b1;
         do @(posedge mclk_i); while (pready_o !== 1'b1);
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask

   task rst(input s);
      begin
         nrst_i <= 1'b0;
         strap <= s;
         repeat (10) @(posedge mclk_i);
         nrst_i <= 1'b1;
         repeat (10) @(posedge mclk_i);
      end
   endtask

   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
         if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   always @(posedge mclk_i)
      if (pready_o === 1'b1)
      begin
         note = q.pop_front();
         chk({31'h0000_0000, pslverr_o}, {31'h0000_0000, note[32]});
         if (!note[33])
            chk(prdata_o, note[31:0]);
      end

   initial
   begin
      #100000;
      n_mismatch = n_mismatch + 1;
      conclude;
   end

   initial
   begin
      {mclk_i, nrst_i, psel_i, penable_i, pwrite_i, strap} = 6'h00;
      {standby_i, bus_released_i, row_strobe_two_i, card_enable_a_i, card_enable_b_i} = 5'h00;
      paddr_i = 12'h000;
      pwdata_i = 32'h0000_0000;
      n_mismatch = 0;
      cmp_count = 0;
      seed = 32'ha50a7ee0;
      rst(1'b0);
      apb(1'b0, 12'h000, 16'h0000, 16'h0000);
      apb(1'b1, 12'h000, 16'hffff, 16'h0000);
      apb(1'b0, 12'h000, 16'h0000, 16'h37ff);
      apb(1'b1, 12'h004, 16'h0000, 16'h0000);
      apb(1'b0, 12'hffc, 16'h0000, 16'h0000);
      apb(1'b0, 12'h000, 16'h0000, 16'h37ff);
      chk(little_endian_o, 1'b0);
      $display("test register access done");
      // Configuration is complete before any area is used; reserved types never written
      for (i = 0; i < 6; i = i + 1)
      begin
         r = $random(seed);
         v = {2'h0, r[1:0], 1'b0, i[1:0], i[1:0] + 2'h1, i[1:0] + 2'h2, i[2:0], r[3:2]};
         apb(1'b1, 12'h000, v, 16'h0000);
         apb(1'b0, 12'h000, 16'h0000, v);
         chk(area0_burst_len_o, bl(i[1:0]));
         chk(area5_burst_len_o, bl(i[1:0] + 2'h1));
         chk(area6_burst_len_o, bl(i[1:0] + 2'h2));
         chk({area2_dram_o, area3_dram_o, area2_sdram_o, area3_sdram_o, area3_psram_o}, MT[i*5 +: 5]);
         chk({area5_card_o, area6_card_o}, r[3:2]);
      end
      $display("test decode done");
      apb(1'b1, 12'h000, 16'h0017, 16'h0000);
      row_strobe_two_i <= 1'b1;
      card_enable_a_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      chk({endian_strap_pin_oe_o, endian_strap_pin_i}, 2'h3);
      chk({mode_pin_three_oe_o, mode_pin_three_o, mode_pin_four_oe_o, mode_pin_four_o}, 4'he);
      chk({mem_pins_oe_o, strobe_pins_oe_o}, 2'h3);
      standby_i <= 1'b1;
      card_enable_b_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      chk({mem_pins_oe_o, strobe_pins_oe_o, endian_strap_pin_i}, 3'h0);
      chk({mode_pin_three_oe_o, mode_pin_three_o, mode_pin_four_oe_o, mode_pin_four_o}, 4'h5);
      apb(1'b1, 12'h000, 16'h3017, 16'h0000);
      apb(1'b0, 12'h000, 16'h0000, 16'h3017);
      chk({mem_pins_oe_o, strobe_pins_oe_o, endian_strap_pin_i}, 3'h7);
      chk({mode_pin_three_oe_o, mode_pin_three_o, mode_pin_four_oe_o, mode_pin_four_o}, 4'hf);
      standby_i <= 1'b0;
      bus_released_i <= 1'b1;
      apb(1'b1, 12'h000, 16'h2017, 16'h0000);
      apb(1'b0, 12'h000, 16'h0000, 16'h2017);
      chk({mem_pins_oe_o, strobe_pins_oe_o}, 2'h2);
      $display("test pin control done");
      rst(1'b1);
      apb(1'b0, 12'h000, 16'h0000, 16'h0800);
      chk(little_endian_o, 1'b1);
      // Card enables and row strobe are still high, so only the cleared bits keep these pins quiet
      chk({mode_pin_three_oe_o, mode_pin_three_o, mode_pin_four_oe_o, mode_pin_four_o, endian_strap_pin_oe_o}, 5'h00);
      apb(1'b1, 12'h000, 16'h0000, 16'h0000);
      apb(1'b0, 12'h000, 16'h0000, 16'h0800);
      $display("test strap done");
      conclude;
   end
endmodule // bus_control_config_register_tb_top
